/* File: verilog/uma_params.svh */
/*
  Constants for the multiprocessor address match receiver and its master.
  Assumes inclusion by bare name from both ends of the serial link.
*/
`ifndef UMA_PARAMS_SVH
`define UMA_PARAMS_SVH

`define UMA_SLV_ADDR_OFS  8'hA9
`define UMA_SLV_MASK_OFS  8'hB9
`define UMA_REG_RST       8'h00
`define UMA_UNMAPPED_RD   8'h00
`define UMA_OSR           16
`define UMA_SMP_FIRST     4'h7
`define UMA_SMP_SECOND    4'h8
`define UMA_SMP_LAST      4'h9
`define UMA_LAST_DATA     3'h7
`define UMA_MODE_SYNC     2'h0
`define UMA_MODE_10BIT    2'h1
`define UMA_LEN_10BIT     4'hA
`define UMA_LEN_11BIT     4'hB
`define UMA_PRESCALE_DEF  8

`endif

/* File: verilog/uma_pkg.sv */
/*
  Types shared by both ends of the multiprocessor serial link.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none

package uma_pkg;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_NINTH,
    RX_STOP
  } uma_rx_state_t;

  typedef enum logic {
    TX_IDLE,
    TX_SHIFT
  } uma_tx_state_t;

  typedef struct packed {
    uma_rx_state_t state;
    logic [7:0]    pre_cnt;
    logic [3:0]    os_cnt;
    logic [2:0]    bit_cnt;
    logic [1:0]    smp;
    logic [7:0]    shreg;
    logic          ninth;
    logic          line_q;
    logic [7:0]    slv_addr;
    logic [7:0]    slv_mask;
    logic          rx_done;
    logic          rx_ninth;
    logic [7:0]    rx_data;
    logic [7:0]    rdata;
  } uma_slv_st_t;

  typedef struct packed {
    uma_tx_state_t state;
    logic [11:0]   per_cnt;
    logic [3:0]    bits_left;
    logic [9:0]    shreg;
    logic          line;
    logic          busy;
    logic          sent;
    logic          refused;
    logic          addr_seen;
  } uma_mst_st_t;

endpackage

`default_nettype wire

/* File: verilog/uma_link_if.sv */
/*
  Single-wire asynchronous serial link from master to slave.
  Assumes the master end drives the line; the slave only listens.
*/
`timescale 1ns/10ps
`default_nettype none

interface uma_link_if;
  logic serial_line;

  modport master (output serial_line);
  modport slave  (input  serial_line);
endinterface

`default_nettype wire

/* File: verilog/uma_slave.sv */
/*
  Slave receiver with hardware address recognition for modes 1, 2 and 3.
  Assumes the serial line is synchronous to mclk_i and that software
  drives the multiprocessor enable, mode and flag clear as plain inputs.
*/
// Contract
// RL1 - Ninth bit marks address only in modes 2, 3
// RL2 - Multiproc on: flag only on address match
// RL3 - Master sends address frames with ninth high
// RL4 - Master sends address first, then data
// RL5 - Waiting slave keeps multiprocessor mode enabled
// RL6 - Addressed slave disables multiprocessor mode for data
// RL7 - Multiproc off: every complete frame sets flag
// RL8 - Mode 1 ninth bit is stop bit
// RL9 - Mode 1 multiproc: valid frame and match
// RL10 - Slave address held in 8-bit register
// RL11 - Mask zero bits make address bits don't care
// RL12 - Broadcast is address OR mask, zeros ignored
// RL13 - Both registers reset to zero, no selectivity
// RL14 - Load only if flag clear and condition met
// RL15 - Eleven-bit modes store ninth bit on accept
// RL16 - Unmatched address leaves state untouched, rewait start
`timescale 1ns/10ps
`default_nettype none
`include "uma_params.svh"

module uma_slave
  import uma_pkg::*;
#(
  parameter int PRESCALE = `UMA_PRESCALE_DEF
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  uma_link_if.slave       link,
  input  wire logic [1:0] mode_i,
  input  wire logic       rx_enable_i,
  input  wire logic       multiproc_enable_i,
  input  wire logic       rx_done_clr_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  output var  logic       rx_done_flag_o,
  output var  logic       rx_ninth_bit_o,
  output var  logic [7:0] rx_data_o,
  output var  logic [7:0] sfr_rdata_o
);

  localparam logic [7:0] PRE_LAST = 8'(PRESCALE - 1);

  localparam uma_slv_st_t SLV_RESET = '{
    state:    RX_IDLE,
    pre_cnt:  8'h00,
    os_cnt:   4'h0,
    bit_cnt:  3'h0,
    smp:      2'h0,
    shreg:    8'h00,
    ninth:    1'b0,
    line_q:   1'b1,
    slv_addr: `UMA_REG_RST,
    slv_mask: `UMA_REG_RST,
    rx_done:  1'b0,
    rx_ninth: 1'b0,
    rx_data:  8'h00,
    rdata:    8'h00
  };

  generate
    if (PRESCALE < 1 || PRESCALE > 256) begin : g_bad_prescale
      $error("uma_slave: PRESCALE must lie in 1..256");
    end
  endgenerate

  uma_slv_st_t st_ff;
  uma_slv_st_t nxt_st;

  logic       line;
  logic       tick;
  logic       mid_bit;
  logic       vote;
  logic       eleven;
  logic       ninth_rx;
  logic [7:0] bcast;
  logic       given_hit;
  logic       bcast_hit;
  logic       accept;

  assign line   = link.serial_line;
  assign tick   = (st_ff.pre_cnt == PRE_LAST);
  assign mid_bit = tick && (st_ff.os_cnt == `UMA_SMP_LAST);
  assign vote   = (st_ff.smp[0] & st_ff.smp[1]) |
                  (st_ff.smp[0] & line) |
                  (st_ff.smp[1] & line);
  assign eleven = mode_i[1];

  // Mode 1 has no ninth data bit; the stop bit takes its place [RL1] [RL8]
  assign ninth_rx = eleven ? st_ff.ninth : vote;

  // Mask zeros drop address bits from the compare [RL10] [RL11]
  assign given_hit = ((st_ff.shreg ^ st_ff.slv_addr) & st_ff.slv_mask)
                     == 8'h00;

  // Only the ones of address OR mask must be present [RL12]
  assign bcast     = st_ff.slv_addr | st_ff.slv_mask;
  assign bcast_hit = (st_ff.shreg & bcast) == bcast;

  // Acceptance at mid stop bit [RL2] [RL7] [RL9] [RL14]
  assign accept = !st_ff.rx_done &&
                  (!multiproc_enable_i ||
                   (ninth_rx && (given_hit || bcast_hit)));

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.line_q = line;

    // Set wins over a software clear arriving in the same cycle
    if (rx_done_clr_i) begin
      nxt_st.rx_done = 1'b0;
    end

    if (sfr_wr_i && sfr_addr_i == `UMA_SLV_ADDR_OFS) begin
      nxt_st.slv_addr = sfr_wdata_i; // [RL10]
    end else if (sfr_wr_i && sfr_addr_i == `UMA_SLV_MASK_OFS) begin
      nxt_st.slv_mask = sfr_wdata_i; // [RL11]
    end

    // Read data is the register value before any same-cycle write
    if (sfr_addr_i == `UMA_SLV_ADDR_OFS) begin
      nxt_st.rdata = st_ff.slv_addr;
    end else if (sfr_addr_i == `UMA_SLV_MASK_OFS) begin
      nxt_st.rdata = st_ff.slv_mask;
    end else begin
      nxt_st.rdata = `UMA_UNMAPPED_RD;
    end

    if (st_ff.state != RX_IDLE) begin
      if (tick) begin
        nxt_st.pre_cnt = 8'h00;
        nxt_st.os_cnt  = st_ff.os_cnt + 4'h1;
      end else begin
        nxt_st.pre_cnt = st_ff.pre_cnt + 8'h01;
      end
      if (tick && st_ff.os_cnt == `UMA_SMP_FIRST) begin
        nxt_st.smp[0] = line;
      end
      if (tick && st_ff.os_cnt == `UMA_SMP_SECOND) begin
        nxt_st.smp[1] = line;
      end
    end

    case (st_ff.state)
      RX_IDLE: begin
        // Mode 0 is synchronous and not served by this receiver
        if (rx_enable_i && mode_i != `UMA_MODE_SYNC &&
            st_ff.line_q && !line) begin
          nxt_st.state   = RX_START;
          nxt_st.pre_cnt = 8'h00;
          nxt_st.os_cnt  = 4'h0;
          nxt_st.bit_cnt = 3'h0;
        end
      end
      RX_START: begin
        if (mid_bit) begin
          // A glitch is dropped here rather than framed as data
          nxt_st.state = vote ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (mid_bit) begin
          nxt_st.shreg   = {vote, st_ff.shreg[7:1]};
          nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
          if (st_ff.bit_cnt == `UMA_LAST_DATA) begin
            nxt_st.state = eleven ? RX_NINTH : RX_STOP; // [RL1]
          end
        end
      end
      RX_NINTH: begin
        if (mid_bit) begin
          nxt_st.ninth = vote; // [RL1]
          nxt_st.state = RX_STOP;
        end
      end
      RX_STOP: begin
        if (mid_bit) begin
          // Back to edge search from the middle of the stop bit [RL16]
          nxt_st.state = RX_IDLE;
          if (accept) begin
            nxt_st.rx_data  = st_ff.shreg; // [RL14]
            nxt_st.rx_ninth = ninth_rx;    // [RL15] [RL8]
            nxt_st.rx_done  = 1'b1;        // [RL2] [RL7] [RL9]
          end
          // No else: a miss leaves buffer and flags as they were [RL16]
        end
      end
      default: begin
        nxt_st.state = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= SLV_RESET; // [RL13]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rx_done_flag_o = st_ff.rx_done;
  assign rx_ninth_bit_o = st_ff.rx_ninth;
  assign rx_data_o      = st_ff.rx_data;
  assign sfr_rdata_o    = st_ff.rdata;

endmodule

`default_nettype wire

/* File: verilog/uma_master.sv */
/*
  Master transmitter that sends address and data frames to the slaves.
  Assumes the slave end samples at sixteen times the bit rate and shares
  the PRESCALE setting and the mode.
*/
`timescale 1ns/10ps
`default_nettype none
`include "uma_params.svh"

module uma_master
  import uma_pkg::*;
#(
  parameter int PRESCALE = `UMA_PRESCALE_DEF
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  uma_link_if.master      link,
  input  wire logic [1:0] mode_i,
  input  wire logic       send_i,
  input  wire logic       send_addr_i,
  input  wire logic [7:0] send_data_i,
  output var  logic       busy_o,
  output var  logic       sent_o,
  output var  logic       refused_o
);

  localparam int          BIT_CYC  = PRESCALE * `UMA_OSR;
  localparam logic [11:0] PER_LAST = 12'(BIT_CYC - 1);

  localparam uma_mst_st_t MST_RESET = '{
    state:     TX_IDLE,
    per_cnt:   12'h000,
    bits_left: 4'h0,
    shreg:     10'h000,
    line:      1'b1,
    busy:      1'b0,
    sent:      1'b0,
    refused:   1'b0,
    addr_seen: 1'b0
  };

  generate
    if (PRESCALE < 1 || PRESCALE > 256) begin : g_bad_prescale
      $error("uma_master: PRESCALE must lie in 1..256");
    end
  endgenerate

  uma_mst_st_t st_ff;
  uma_mst_st_t nxt_st;

  logic        ninth_tx;
  logic [10:0] frame;
  logic        legal;

  // In modes 2 and 3 address frames carry a high ninth bit, data frames a low one [RL3]
  assign ninth_tx = send_addr_i;
  assign frame = mode_i[1] ? {1'b1, ninth_tx, send_data_i, 1'b0}
                           : {1'b1, 1'b1, send_data_i, 1'b0};

  // Data is only sent once some slave has been addressed [RL4]
  assign legal = mode_i != `UMA_MODE_SYNC &&
                 (send_addr_i || st_ff.addr_seen);

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.sent    = 1'b0;
    nxt_st.refused = 1'b0;
    case (st_ff.state)
      TX_IDLE: begin
        if (send_i && legal) begin
          nxt_st.state     = TX_SHIFT;
          nxt_st.busy      = 1'b1;
          nxt_st.line      = frame[0];
          nxt_st.shreg     = frame[10:1];
          nxt_st.per_cnt   = 12'h000;
          nxt_st.bits_left = (mode_i == `UMA_MODE_10BIT) ?
                             `UMA_LEN_10BIT - 4'h1 : `UMA_LEN_11BIT - 4'h1;
          nxt_st.addr_seen = st_ff.addr_seen | send_addr_i; // [RL4]
        end else if (send_i) begin
          nxt_st.refused = 1'b1;
        end
      end
      TX_SHIFT: begin
        if (send_i) begin
          nxt_st.refused = 1'b1;
        end
        if (st_ff.per_cnt == PER_LAST) begin
          nxt_st.per_cnt = 12'h000;
          if (st_ff.bits_left == 4'h0) begin
            nxt_st.state = TX_IDLE;
            nxt_st.busy  = 1'b0;
            nxt_st.sent  = 1'b1;
          end else begin
            nxt_st.line      = st_ff.shreg[0];
            nxt_st.shreg     = {1'b1, st_ff.shreg[9:1]};
            nxt_st.bits_left = st_ff.bits_left - 4'h1;
          end
        end else begin
          nxt_st.per_cnt = st_ff.per_cnt + 12'h001;
        end
      end
      default: begin
        nxt_st = MST_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= MST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign link.serial_line = st_ff.line;
  assign busy_o           = st_ff.busy;
  assign sent_o           = st_ff.sent;
  assign refused_o        = st_ff.refused;

endmodule

`default_nettype wire

/* File: bench/uma_props.sv */
/*
  Checker for the slave flag, receive outputs and register port.
  Assumes instantiation beside the link interface in the bench top.
*/
`timescale 1ns/10ps
`default_nettype none

module uma_props (
  input wire logic       mclk_i,
  input wire logic       rstn_i,
  input wire logic       serial_line,
  input wire logic       rx_done_clr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       rx_done_flag_o,
  input wire logic       rx_ninth_bit_o,
  input wire logic [7:0] rx_data_o,
  input wire logic [7:0] sfr_rdata_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence addr_wr_s;
    sfr_wr_i && sfr_addr_i == 8'hA9;
  endsequence
  sequence addr_hold_s;
    !sfr_wr_i && sfr_addr_i == 8'hA9;
  endsequence

  chk_addr_readback: assert property (
    addr_wr_s ##1 addr_hold_s |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
    else $error("slave address read back wrong");
  chk_unmapped_zero: assert property (
    sfr_addr_i != 8'hA9 && sfr_addr_i != 8'hB9 |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_flag_holds: assert property (
    rx_done_flag_o && !rx_done_clr_i |=> rx_done_flag_o)
    else $error("flag dropped without clear");
  chk_flag_clears: assert property (
    rx_done_flag_o && rx_done_clr_i |=> !rx_done_flag_o)
    else $error("flag not cleared");
  chk_data_frozen: assert property (
    rx_done_flag_o |=> $stable(rx_data_o) && $stable(rx_ninth_bit_o))
    else $error("frame loaded while flag set");
  chk_data_on_accept: assert property (
    !$stable(rx_data_o) |-> $rose(rx_done_flag_o))
    else $error("data changed without accept");
  chk_ninth_on_accept: assert property (
    !$stable(rx_ninth_bit_o) |-> $rose(rx_done_flag_o))
    else $error("ninth bit changed without accept");
  chk_stop_seen: assert property (
    $rose(rx_done_flag_o) |-> serial_line && $past(serial_line, 3))
    else $error("accept outside stop bit");
  // Every bit lasts at least sixteen clocks, so a low run is never shorter
  chk_start_width: assert property (
    $fell(serial_line) |-> !serial_line [*8])
    else $error("low bit too short");
endmodule

`default_nettype wire

/* File: bench/uart_multiproc_address_match_bench.sv */
/*
  Bench joining master and slave over the link and checking acceptance.
  Assumes PRESCALE of 1 on both ends, so one bit is sixteen clocks.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end

module uart_multiproc_address_match_bench;
  logic       mclk_i    = 1'b0;
  logic       rstn_i    = 1'b0;
  logic [1:0] mode      = 2'h3;
  logic       mp_en     = 1'b1;
  logic       rx_en     = 1'b1;
  logic       busy;
  logic       refused;
  logic       clr       = 1'b0;
  logic       wr        = 1'b0;
  logic       send      = 1'b0;
  logic       send_addr = 1'b0;
  logic [7:0] addr      = 8'h00;
  logic [7:0] wdata     = 8'h00;
  logic [7:0] sdata     = 8'h00;
  logic       flag;
  logic       ninth;
  logic       sent;
  logic [7:0] rxd;
  logic [7:0] rdata;
  int         bad_count = 0;
  int         checks    = 0;
  int         cycles    = 0;

  uma_link_if u_link ();
  uma_master #(.PRESCALE(1)) u_uma_master (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .link(u_link), .mode_i(mode), .send_i(send),
    .send_addr_i(send_addr), .send_data_i(sdata), .busy_o(busy),
    .sent_o(sent), .refused_o(refused));
  // Receive enable is driven so a gated start can be shown to be ignored
  uma_slave #(.PRESCALE(1)) u_uma_slave (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .link(u_link), .mode_i(mode), .rx_enable_i(rx_en),
    .multiproc_enable_i(mp_en), .rx_done_clr_i(clr), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_wdata_i(wdata), .rx_done_flag_o(flag),
    .rx_ninth_bit_o(ninth), .rx_data_o(rxd), .sfr_rdata_o(rdata));
  uma_props u_props (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .serial_line(u_link.serial_line), .rx_done_clr_i(clr),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
    .rx_done_flag_o(flag), .rx_ninth_bit_o(ninth), .rx_data_o(rxd),
    .sfr_rdata_o(rdata));

  always #12.5 mclk_i = ~mclk_i;

  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 10000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge mclk_i);
    wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk_i);
    addr = a;
    @(negedge mclk_i);
    `CHK(rdata, e)
  endtask

  // Requests the master must drop; the line stays idle
  task automatic refuse(input logic a, input logic [7:0] d);
    @(negedge mclk_i);
    send = 1'b1;
    send_addr = a;
    sdata = d;
    @(negedge mclk_i);
    send = 1'b0;
    `CHK(refused, 1'b1)
    `CHK(busy, 1'b0)
  endtask

  task automatic clear();
    @(negedge mclk_i);
    clr = 1'b1;
    @(negedge mclk_i);
    clr = 1'b0;
  endtask

  // Sends one frame, then checks flag, byte and ninth bit after the stop
  task automatic frame(input logic a, input logic [7:0] d, input logic f,
                       input logic [7:0] x, input logic n);
    int k;
    @(negedge mclk_i);
    send = 1'b1;
    send_addr = a;
    sdata = d;
    @(negedge mclk_i);
    send = 1'b0;
    `CHK(busy, 1'b1)
    for (k = 0; k < 400 && sent !== 1'b1; k++) @(negedge mclk_i);
    `CHK(sent, 1'b1)
    `CHK(flag, f)
    `CHK(rxd, x)
    `CHK(ninth, n)
  endtask

  initial begin
    repeat (20) @(negedge mclk_i);
    rstn_i = 1'b1;
    rd_chk(8'hA9, 8'h00);
    rd_chk(8'hB9, 8'h00);
    rd_chk(8'h3C, 8'h00);
    refuse(1'b0, 8'h11);
    frame(1'b1, 8'h37, 1'b1, 8'h37, 1'b1);
    clear();
    wr_reg(8'hA9, 8'hA4);
    rd_chk(8'hA9, 8'hA4);
    wr_reg(8'hB9, 8'hFA);
    rd_chk(8'hB9, 8'hFA);
    frame(1'b1, 8'hA3, 1'b0, 8'h37, 1'b1);
    frame(1'b1, 8'hA0, 1'b1, 8'hA0, 1'b1);
    clear();
    frame(1'b1, 8'h7E, 1'b0, 8'hA0, 1'b1);
    frame(1'b1, 8'hFF, 1'b1, 8'hFF, 1'b1);
    clear();
    frame(1'b0, 8'hA5, 1'b0, 8'hFF, 1'b1);
    frame(1'b1, 8'hA5, 1'b1, 8'hA5, 1'b1);
    clear();
    mp_en = 1'b0;
    frame(1'b0, 8'h5C, 1'b1, 8'h5C, 1'b0);
    frame(1'b0, 8'h3E, 1'b1, 8'h5C, 1'b0);
    clear();
    mode = 2'h1;
    mp_en = 1'b1;
    frame(1'b1, 8'hA3, 1'b0, 8'h5C, 1'b0);
    frame(1'b1, 8'hA1, 1'b1, 8'hA1, 1'b1);
    clear();
    rx_en = 1'b0;
    frame(1'b1, 8'hA1, 1'b0, 8'hA1, 1'b1);
    mode = 2'h0;
    refuse(1'b1, 8'hA1);
    finish_test();
  end
endmodule

`default_nettype wire
